// File: inc/lcc_pkg.sv
// package of constants and types for the charge control sequencer
package lcc_pkg;
  localparam int CLK_HZ = 40000000;
  localparam int OVP_DGL_US = 115;
  localparam int REC_DGL_MS = 25;
  localparam int TS_DGL_MS = 25;
  localparam int SOFT_START_US = 1000;
  localparam int OVP_DGL_CYC = OVP_DGL_US * (CLK_HZ / 1000000);
  localparam int REC_DGL_CYC = REC_DGL_MS * (CLK_HZ / 1000);
  localparam int TS_DGL_CYC = TS_DGL_MS * (CLK_HZ / 1000);
  localparam int SOFT_START_CYC = SOFT_START_US * (CLK_HZ / 1000000);
  localparam int PRECHARGE_UA = 47500;
  localparam int CNT_W = 21;
  localparam logic [1:0] TARGET_OVERCHARGE = 2'h0;
  localparam logic [1:0] TARGET_FLOAT = 2'h1;
  localparam logic [1:0] TARGET_NONE = 2'h2;
  typedef enum logic [6:0]
  {
    ST_POWER_DOWN = 7'h01,
    ST_SOFT_START = 7'h02,
    ST_IDLE = 7'h04,
    ST_SELECT = 7'h08,
    ST_PRECHARGE = 7'h10,
    ST_FAST = 7'h20,
    ST_DONE = 7'h40
  } lcc_state_t;
endpackage

// File: logic/lcc_sync.sv
`timescale 1ns/10ps
// two-flop synchroniser for comparator flags
module lcc_sync
#(
  parameter int WIDTH = 1
)
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_reg;

  // first stage is read only by the second
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      meta_reg <= '0;
      q <= '0;
    end
    else
    begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule

// File: logic/lcc_deglitch.sv
`timescale 1ns/10ps
// qualifies a level: output follows only after it held for CYCLES clocks, except a set-only release, which is immediate
module lcc_deglitch
#(
  parameter int CYCLES = 4,
  parameter int CNT_W = 21,
  parameter bit SET_ONLY = 1'b0
)
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic level,
  output logic qualified
);
  logic [CNT_W-1:0] cnt_reg;
  logic hit;

  // refused at elaboration: the counter could never reach the count
  if (CYCLES < 1 || CYCLES >= (1 << CNT_W))
  begin : g_bad_cycles
    $error("lcc_deglitch: CYCLES does not fit the counter");
  end

  assign hit = (cnt_reg == CNT_W'(CYCLES - 1));

  // counter restarts whenever level agrees with the output, so short excursions vanish
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      cnt_reg <= '0;
      qualified <= 1'b0;
    end
    else if (level == qualified || (SET_ONLY && !level))
    begin
      cnt_reg <= '0;
      if (SET_ONLY && !level)
        qualified <= 1'b0; // release is immediate in set-only mode
    end
    else if (hit)
    begin
      cnt_reg <= '0;
      qualified <= level;
    end
    else
      cnt_reg <= cnt_reg + CNT_W'(1);
  end
endmodule

// File: logic/lcc_charge_fsm.sv
`timescale 1ns/10ps
// charge control sequencer for a single lithium iron phosphate cell
module lcc_charge_fsm
  import lcc_pkg::*;
#(
  parameter int OVP_CYCLES = OVP_DGL_CYC,
  parameter int REC_CYCLES = REC_DGL_CYC,
  parameter int TS_CYCLES = TS_DGL_CYC,
  parameter int SS_CYCLES = SOFT_START_CYC
)
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic IN_ABOVE_INPUT_UNDERVOLTAGE_POWERDOWN,
  input wire logic IN_ABOVE_OVP,
  input wire logic BAT_ABOVE_PRECHARGE,
  input wire logic BAT_AT_OVERCHARGE,
  input wire logic BAT_BELOW_RECHARGE,
  input wire logic TS_ABOVE_COLD,
  input wire logic TS_BELOW_HOT,
  input wire logic CHARGE_ENABLE,
  output logic AUX_REG_EN,
  output logic PASS_EN,
  output logic PRECHARGE_MODE,
  output logic FAST_MODE,
  output logic [1:0] REG_TARGET,
  output logic STATUS_OUT,
  output logic STATUS_OE,
  output logic OVP_SHUTDOWN,
  output logic TS_SUSPEND
);
  import lcc_pkg::*;

  // refused at elaboration: soft-start counter too narrow for the count
  if (SS_CYCLES < 1 || SS_CYCLES >= (1 << CNT_W))
  begin : g_bad_ss
    $error("lcc_charge_fsm: SS_CYCLES does not fit the counter");
  end

  ////////////////////////////////////////////////////////////////////////
  // input synchronisation

  logic [7:0] raw_flags;
  logic [7:0] sync_flags;
  logic input_undervoltage_powerdown_ok, ovp_raw, bat_pre, bat_ovch, bat_rec_raw;
  logic ts_cold_ok, ts_hot_ok, enable_s;

  assign raw_flags = {IN_ABOVE_INPUT_UNDERVOLTAGE_POWERDOWN, IN_ABOVE_OVP, BAT_ABOVE_PRECHARGE,
                      BAT_AT_OVERCHARGE, BAT_BELOW_RECHARGE,
                      TS_ABOVE_COLD, TS_BELOW_HOT, CHARGE_ENABLE};

  // all comparator flags cross into the clock here
  lcc_sync #(.WIDTH(8)) u_sync
  (
    .CLK(CLK),
    .RST_N(RST_N),
    .d(raw_flags),
    .q(sync_flags)
  );

  assign input_undervoltage_powerdown_ok = sync_flags[7];
  assign ovp_raw = sync_flags[6];
  assign bat_pre = sync_flags[5];
  assign bat_ovch = sync_flags[4];
  assign bat_rec_raw = sync_flags[3];
  assign ts_cold_ok = sync_flags[2];
  assign ts_hot_ok = sync_flags[1];
  assign enable_s = sync_flags[0];

  ////////////////////////////////////////////////////////////////////////
  // deglitch filters

  logic ovp_dgl, rec_dgl, ts_fault_raw, ts_fault_dgl;

  // thermistor outside cold..hot window is a fault
  assign ts_fault_raw = !(ts_cold_ok && ts_hot_ok);

  // over-voltage trips after 115 us, clears as soon as input falls
  lcc_deglitch #(.CYCLES(OVP_CYCLES), .CNT_W(CNT_W), .SET_ONLY(1'b1))
    u_ovp_dgl
  (
    .CLK(CLK),
    .RST_N(RST_N),
    .level(ovp_raw),
    .qualified(ovp_dgl)
  );

  // recharge fall qualified for 25 ms
  lcc_deglitch #(.CYCLES(REC_CYCLES), .CNT_W(CNT_W), .SET_ONLY(1'b1))
    u_rec_dgl
  (
    .CLK(CLK),
    .RST_N(RST_N),
    .level(bat_rec_raw),
    .qualified(rec_dgl)
  );

  // thermistor fault qualified for 25 ms both ways
  lcc_deglitch #(.CYCLES(TS_CYCLES), .CNT_W(CNT_W), .SET_ONLY(1'b0))
    u_ts_dgl
  (
    .CLK(CLK),
    .RST_N(RST_N),
    .level(ts_fault_raw),
    .qualified(ts_fault_dgl)
  );

  ////////////////////////////////////////////////////////////////////////
  // over-voltage latch

  logic ovp_reg, ovp_next, powered;

  // sets only once soft-start is over, so a hot plug-in finishes
  // powering up first; held until the raw level falls
  assign ovp_next = ovp_raw && (ovp_reg || (ovp_dgl && powered));

  ////////////////////////////////////////////////////////////////////////
  // state machine

  lcc_state_t state_reg, state_next;
  logic [CNT_W-1:0] ss_cnt_reg, ss_cnt_next;
  logic ss_done, blocked;

  assign ss_done = (ss_cnt_reg == CNT_W'(SS_CYCLES - 1));
  // over-voltage only acts once soft-start has finished
  assign blocked = ovp_reg;

  always_comb
  begin
    state_next = state_reg;
    ss_cnt_next = '0;
    if (!input_undervoltage_powerdown_ok)
      state_next = ST_POWER_DOWN; // control input ignored here
    else
    begin
      case (state_reg)
        ST_POWER_DOWN:
          state_next = ST_SOFT_START; // internal circuitry powers up
        ST_SOFT_START:
        begin
          ss_cnt_next = ss_cnt_reg + CNT_W'(1);
          if (ss_done)
            state_next = ST_IDLE;
        end
        ST_IDLE:
          if (enable_s && !blocked)
            state_next = ST_SELECT;
        ST_SELECT:
          // stage chosen from battery level
          state_next = bat_pre ? ST_FAST : ST_PRECHARGE;
        ST_PRECHARGE:
          if (bat_pre)
            state_next = ST_FAST;
        ST_FAST:
          if (bat_ovch)
            state_next = ST_DONE;
        ST_DONE:
          // stays enabled at float until recharge qualifies
          if (rec_dgl)
            state_next = ST_SELECT;
        default:
          state_next = ST_POWER_DOWN;
      endcase
      // disable or over-voltage returns to idle once powered
      if ((state_reg == ST_SELECT || state_reg == ST_PRECHARGE ||
           state_reg == ST_FAST || state_reg == ST_DONE) &&
          (!enable_s || blocked))
        state_next = ST_IDLE;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      state_reg <= ST_POWER_DOWN;
      ss_cnt_reg <= '0;
      ovp_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      ss_cnt_reg <= ss_cnt_next;
      ovp_reg <= ovp_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // output decode

  logic charging_next, pre_next, fast_next, done_next;
  logic aux_next, pass_next, status_low_next, susp_next;
  logic [1:0] target_next;

  assign powered = input_undervoltage_powerdown_ok && state_reg != ST_POWER_DOWN &&
                   state_reg != ST_SOFT_START;
  assign pre_next = state_next == ST_PRECHARGE;
  assign fast_next = state_next == ST_FAST;
  assign done_next = state_next == ST_DONE;
  assign charging_next = pre_next || fast_next;
  // thermistor suspends charging, resumes without new enable
  assign susp_next = charging_next && ts_fault_dgl;
  // regulator follows supply window only, never the enable
  assign aux_next = input_undervoltage_powerdown_ok && state_reg != ST_POWER_DOWN && !ovp_next;
  // pass element off in power-down and while suspended
  assign pass_next = powered && (charging_next || done_next) && !susp_next;
  // status stays low even when suspended by thermistor
  assign status_low_next = charging_next;
  assign target_next = done_next ? TARGET_FLOAT :
                       charging_next ? TARGET_OVERCHARGE : TARGET_NONE;

  // outputs registered; status is open-drain, oe high pulls low
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      AUX_REG_EN <= 1'b0;
      PASS_EN <= 1'b0;
      PRECHARGE_MODE <= 1'b0;
      FAST_MODE <= 1'b0;
      REG_TARGET <= TARGET_NONE;
      STATUS_OUT <= 1'b0;
      STATUS_OE <= 1'b0;
      OVP_SHUTDOWN <= 1'b0;
      TS_SUSPEND <= 1'b0;
    end
    else
    begin
      AUX_REG_EN <= aux_next;
      PASS_EN <= pass_next;
      PRECHARGE_MODE <= pre_next && !susp_next;
      FAST_MODE <= fast_next && !susp_next;
      REG_TARGET <= target_next;
      STATUS_OUT <= 1'b0;
      STATUS_OE <= status_low_next; // released when done or off
      OVP_SHUTDOWN <= ovp_next;
      TS_SUSPEND <= susp_next;
    end
  end
endmodule

// File: bench/lcc_fsm_asserts.sv
// concurrent checks on the charge sequencer ports
`timescale 1ns/10ps
module lcc_fsm_asserts
  import lcc_pkg::*;
#(
  parameter int OVP_CYCLES = 8,
  parameter int TS_CYCLES = 16
)
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic IN_ABOVE_INPUT_UNDERVOLTAGE_POWERDOWN,
  input wire logic IN_ABOVE_OVP,
  input wire logic TS_ABOVE_COLD,
  input wire logic TS_BELOW_HOT,
  input wire logic AUX_REG_EN,
  input wire logic PASS_EN,
  input wire logic PRECHARGE_MODE,
  input wire logic [1:0] REG_TARGET,
  input wire logic STATUS_OE,
  input wire logic OVP_SHUTDOWN,
  input wire logic TS_SUSPEND
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // pack out of window on either side
  wire logic ts_bad = !(TS_ABOVE_COLD && TS_BELOW_HOT);
  ////////////////////////////////////////////////////////////////
  // flags pass two sync flops and a register, so allow four clocks
  sequence s_uv_low; !IN_ABOVE_INPUT_UNDERVOLTAGE_POWERDOWN [*4]; endsequence
  sequence s_in_ok; (IN_ABOVE_INPUT_UNDERVOLTAGE_POWERDOWN && !IN_ABOVE_OVP) [*8]; endsequence
  AST_UV_OFF: assert property
    (s_uv_low |-> !(AUX_REG_EN || PASS_EN || STATUS_OE))
    else $error("output on below input_undervoltage_powerdown");
  AST_AUX_ON: assert property
    (s_in_ok |-> AUX_REG_EN) else $error("aux off in valid supply");
  AST_OVP_OFF: assert property
    (OVP_SHUTDOWN [*2] |-> !(AUX_REG_EN || PASS_EN))
    else $error("aux or pass on in shutdown");
  AST_OVP_QUAL: assert property
    ($rose(OVP_SHUTDOWN) |-> $past(IN_ABOVE_OVP, OVP_CYCLES))
    else $error("shutdown without held overvoltage");
  AST_PRE_LOW: assert property
    (PRECHARGE_MODE |-> STATUS_OE) else $error("status off in precharge");
  AST_DONE_REL: assert property
    ((REG_TARGET == TARGET_FLOAT) [*2] |-> !STATUS_OE)
    else $error("status low after completion");
  AST_TS_OFF: assert property
    (TS_SUSPEND [*2] |-> !PASS_EN) else $error("pass on in suspend");
  AST_TS_QUAL: assert property
    ($rose(TS_SUSPEND) |-> $past(ts_bad, TS_CYCLES))
    else $error("suspend without held fault");
endmodule

// File: bench/lcc_env_model.sv
// comparator front end turning bench levels in mV into flags
`timescale 1ns/10ps
module lcc_env_model
(
  input wire logic CLK,
  input wire logic signed [31:0] vin_mv,
  input wire logic signed [31:0] vbat_mv,
  input wire logic signed [31:0] ts_mv,
  output logic in_ok = 1'b0,
  output logic in_ov = 1'b0,
  output logic b_pre = 1'b0,
  output logic b_full = 1'b0,
  output logic b_rec = 1'b0,
  output logic t_cold = 1'b0,
  output logic t_hot = 1'b0
);
  // thresholds in mV, arbitrary bench values
  localparam int UV = 3000, OV = 9000, PRE = 2500, FULL = 3600;
  localparam int REC = 3200, COLD = 2500, HOT = 1000;
  ////////////////////////////////////////////////////////////////
  // comparators settle one clock after a level moves
  always @(posedge CLK)
  begin
    in_ok <= vin_mv > UV;
    in_ov <= vin_mv > OV;
    b_pre <= vbat_mv > PRE;
    b_full <= vbat_mv >= FULL;
    b_rec <= vbat_mv < REC;
    t_cold <= ts_mv < COLD; // divider rises as the pack cools
    t_hot <= ts_mv > HOT;
  end
endmodule

// File: bench/tb_top.sv
// self-checking bench for the charge control sequencer
`timescale 1ns/10ps
module tb_top;
  import lcc_pkg::*;
  localparam int OC = 8, RC = 16, TC = 16, SC = 12, L = 8;
  localparam int PRE = 2500, VOK = 5000, VLO = 1000, VOV = 12000;
  logic CLK = 1'b0;
  logic RST_N = 1'b0;
  logic en = 1'b0;
  int vin = 1000, vb = 3400, ts = 1800;
  int failures = 0, n_checks = 0, b;
  logic [31:0] seed = 32'he469;
  wire logic uv, ov, bp, bf, br, tc, th, aux, pass, pre, fast;
  wire logic s_out, s_oe, ovsd, tsus;
  wire logic [1:0] tgt;
  // open-drain status line with its pull-up
  wire logic stat = s_oe ? s_out : 1'b1;
  ////////////////////////////////////////////////////////////////
  lcc_env_model u_env
  (
    .CLK(CLK), .vin_mv(vin), .vbat_mv(vb), .ts_mv(ts), .in_ok(uv),
    .in_ov(ov), .b_pre(bp), .b_full(bf), .b_rec(br), .t_cold(tc),
    .t_hot(th)
  );
  lcc_charge_fsm #(.OVP_CYCLES(OC), .REC_CYCLES(RC), .TS_CYCLES(TC),
    .SS_CYCLES(SC)) DUT
  (
    .CLK(CLK), .RST_N(RST_N), .IN_ABOVE_INPUT_UNDERVOLTAGE_POWERDOWN(uv), .IN_ABOVE_OVP(ov),
    .BAT_ABOVE_PRECHARGE(bp), .BAT_AT_OVERCHARGE(bf),
    .BAT_BELOW_RECHARGE(br), .TS_ABOVE_COLD(tc), .TS_BELOW_HOT(th),
    .CHARGE_ENABLE(en), .AUX_REG_EN(aux), .PASS_EN(pass),
    .PRECHARGE_MODE(pre), .FAST_MODE(fast), .REG_TARGET(tgt),
    .STATUS_OUT(s_out), .STATUS_OE(s_oe), .OVP_SHUTDOWN(ovsd),
    .TS_SUSPEND(tsus)
  );
  // 25 ns period
  initial
  begin
    forever #12.5 CLK = ~CLK;
  end
  ////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  // stage from cell level alone: {fast, precharge}
  function automatic logic [1:0] exp_mode(int bt);
    return (bt > PRE) ? 2'b10 : 2'b01;
  endfunction
  task automatic chk(string nm, logic [1:0] exp, logic [1:0] got);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  // levels change at an edge, outputs read 1 ns past the last edge
  task automatic drv(int v, int bt, int t, logic e, int n);
    @(posedge CLK);
    vin <= v;
    vb <= bt;
    ts <= t;
    en <= e;
    repeat (n) @(posedge CLK);
    #1;
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  // hang guard, far beyond the few hundred clocks the tests need
  initial
  begin
    repeat (3000) @(posedge CLK);
    failures++;
    print_verdict();
  end
  initial
  begin
    repeat (8) @(posedge CLK);
    RST_N <= 1'b1;
    drv(VLO, 3400, 1800, 1'b1, 10);
    chk("aux", 0, {aux, pass});
    chk("status", 1, stat);
    chk("target", TARGET_NONE, tgt);
    $display("test powerdown done");
    repeat (4)
    begin
      seed = xs(seed);
      b = 2000 + int'(seed % 32'd1500);
      drv(VOK, b, 1800, 1'b0, SC + L);
      chk("aux", 1, aux);
      drv(VOK, b, 1800, 1'b1, L);
      chk("mode", exp_mode(b), {fast, pre});
      chk("status", 0, stat);
      chk("target", TARGET_OVERCHARGE, tgt);
    end
    drv(VOK, 2000, 1800, 1'b0, L);
    drv(VOK, 2000, 1800, 1'b1, L);
    chk("mode", 2'b01, {fast, pre});
    drv(VOK, 3400, 1800, 1'b1, L);
    chk("mode", 2'b10, {fast, pre});
    drv(VOK, 3700, 1800, 1'b1, L);
    chk("status", 1, stat);
    chk("target", TARGET_FLOAT, tgt);
    drv(VOK, 3400, 1800, 1'b1, L);
    chk("pass", 1, pass);
    drv(VOK, 3000, 1800, 1'b1, RC / 2);
    chk("status", 1, stat);
    drv(VOK, 3000, 1800, 1'b1, RC + L);
    chk("mode", 2'b10, {fast, stat});
    $display("test cycle done");
    drv(VOK, 3400, 500, 1'b1, TC / 2);
    chk("suspend", 0, tsus);
    drv(VOK, 3400, 500, 1'b1, TC + L);
    chk("suspend", 2'b10, {tsus, pass});
    chk("status", 0, stat);
    drv(VOK, 3400, 1800, 1'b1, TC + L);
    chk("suspend", 2'b01, {tsus, pass});
    $display("test thermistor done");
    drv(VOV, 3400, 1800, 1'b1, OC / 2);
    chk("shutdown", 0, ovsd);
    drv(VOK, 3400, 1800, 1'b0, L);
    chk("shutdown", 0, ovsd);
    chk("aux", 1, aux);
    drv(VOV, 3400, 1800, 1'b1, OC + L);
    chk("shutdown", 2'b10, {ovsd, aux});
    chk("pass", 0, pass);
    drv(VOK, 3400, 1800, 1'b1, L);
    chk("shutdown", 2'b01, {ovsd, aux});
    drv(VLO, 3400, 1800, 1'b1, L);
    // deglitch expires inside soft-start: shutdown waits for its end
    drv(VOV, 3400, 1800, 1'b1, SC + 2);
    chk("plugin", 2'b01, {ovsd, aux});
    drv(VOV, 3400, 1800, 1'b1, L);
    chk("plugin", 2'b10, {ovsd, aux});
    $display("test overvoltage done");
    print_verdict();
  end
endmodule
bind lcc_charge_fsm lcc_fsm_asserts #(.OVP_CYCLES(OVP_CYCLES),
  .TS_CYCLES(TS_CYCLES)) u_chk
(
  .CLK(CLK), .RST_N(RST_N), .IN_ABOVE_INPUT_UNDERVOLTAGE_POWERDOWN(IN_ABOVE_INPUT_UNDERVOLTAGE_POWERDOWN),
  .IN_ABOVE_OVP(IN_ABOVE_OVP), .TS_ABOVE_COLD(TS_ABOVE_COLD),
  .TS_BELOW_HOT(TS_BELOW_HOT), .AUX_REG_EN(AUX_REG_EN),
  .PASS_EN(PASS_EN), .PRECHARGE_MODE(PRECHARGE_MODE),
  .REG_TARGET(REG_TARGET), .STATUS_OE(STATUS_OE),
  .OVP_SHUTDOWN(OVP_SHUTDOWN), .TS_SUSPEND(TS_SUSPEND)
);
